// ---- ncsre_consts.svh ----
// Constants for the nibble core execution slice: register port offsets,
// flag bit positions, reset values, opcode patterns and memory pages.
// Assumes inclusion by the decoder, the core and the bench; definitions only.
`ifndef NCSRE_CONSTS_SVH
`define NCSRE_CONSTS_SVH

`define NCSRE_REG_A        4'h0
`define NCSRE_REG_B        4'h1
`define NCSRE_REG_F        4'h2
`define NCSRE_REG_ADDR_HI  4'h3
`define NCSRE_REG_X        4'h4
`define NCSRE_REG_Y        4'h5
`define NCSRE_REG_RSP      4'h6
`define NCSRE_REG_NSP      4'h7
`define NCSRE_REG_PC       4'h8
`define NCSRE_REG_STATUS   4'h9

`define NCSRE_F_E          3
`define NCSRE_F_I          2
`define NCSRE_F_C          1
`define NCSRE_F_Z          0

`define NCSRE_RST_NIB      4'h0
`define NCSRE_RST_BYTE     8'h00
`define NCSRE_RST_WORD     16'h0000

`define NCSRE_PAGE_X       8'h00
`define NCSRE_PAGE_Y       8'hff
`define NCSRE_PAGE_STACK   8'h00

`define NCSRE_OPC_OR_R_MEM 13'b1101101100???
`define NCSRE_OPC_OR_MEM_R 13'b1101101101???
`define NCSRE_OPC_OR_M_IMM 13'b1101100??????
`define NCSRE_OPC_POP_AB   13'b111111110111?
`define NCSRE_OPC_POP_F    13'h1fed
`define NCSRE_OPC_POP_X    13'h1fe9
`define NCSRE_OPC_POP_Y    13'b111111110101?
`define NCSRE_OPC_PUSH_AB  13'b111111110011?
`define NCSRE_OPC_PUSH_F   13'h1fe5
`define NCSRE_OPC_PUSH_X   13'h1fe1
`define NCSRE_OPC_PUSH_Y   13'b111111110001?
`define NCSRE_OPC_EXIT     13'b11111111110?0
`define NCSRE_OPC_EXIT_INT 13'h1ff9
`define NCSRE_OPC_EXIT_SKP 13'h1ffb
`define NCSRE_OPC_EXIT_STB 13'b10001????????
`define NCSRE_OPC_ROT_L    13'b1000011110?10
`define NCSRE_OPC_LD_AHI   13'b01000????????

`endif

// ---- ncsre_pkg.sv ----
// Types shared by the execution slice: operation codes, sequencer steps
// and nibble register selectors. Assumes no other package.
`default_nettype none
package ncsre_pkg;
  typedef enum logic [3:0] {
    OP_NOP       = 4'b0000,
    OP_OR_R_MEM  = 4'b0001,
    OP_OR_MEM_R  = 4'b0010,
    OP_OR_M_IMM  = 4'b0011,
    OP_POP_NIB   = 4'b0100,
    OP_POP_IDX   = 4'b0101,
    OP_PUSH_NIB  = 4'b0110,
    OP_PUSH_IDX  = 4'b0111,
    OP_EXIT      = 4'b1000,
    OP_EXIT_SKP  = 4'b1001,
    OP_EXIT_INT  = 4'b1010,
    OP_EXIT_STB  = 4'b1011,
    OP_ROT_L     = 4'b1100,
    OP_LD_AHI    = 4'b1101
  } ncsre_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_P0   = 3'b001,
    ST_P1   = 3'b010,
    ST_P2   = 3'b011,
    ST_P3   = 3'b100,
    ST_P4   = 3'b101,
    ST_P5   = 3'b110
  } ncsre_state_t;

  typedef enum logic [1:0] {
    RS_A = 2'b00,
    RS_B = 2'b01,
    RS_F = 2'b10
  } ncsre_rsel_t;
endpackage
`default_nettype wire

// ---- ncsre_decode.sv ----
// Opcode decoder for the execution slice.
// Assumes a 13-bit instruction word that is stable while it is decoded.
`timescale 1ns/10ps
`default_nettype none
`include "ncsre_consts.svh"
module ncsre_decode
(
  input  wire logic [12:0]             opcode,
  output var  ncsre_pkg::ncsre_op_t    op,
  output var  ncsre_pkg::ncsre_rsel_t  rsel,
  output var  logic                    use_y,
  output var  logic                    post_inc
);
  import ncsre_pkg::*;

  // Opcodes outside this slice decode as a plain one-cycle step.
  always_comb
  begin
    op       = OP_NOP;
    rsel     = opcode[2] ? RS_B : RS_A;
    use_y    = opcode[1];
    post_inc = 1'b0;
    casez (opcode)
      `NCSRE_OPC_OR_R_MEM: begin op = OP_OR_R_MEM; post_inc = opcode[0]; end
      `NCSRE_OPC_OR_MEM_R: begin op = OP_OR_MEM_R; post_inc = opcode[0]; end
      `NCSRE_OPC_OR_M_IMM:
      begin
        op       = OP_OR_M_IMM;
        use_y    = opcode[5];
        post_inc = opcode[4];
      end
      `NCSRE_OPC_POP_AB:   begin op = OP_POP_NIB; rsel = opcode[0] ? RS_A : RS_B; end
      `NCSRE_OPC_POP_F:    begin op = OP_POP_NIB; rsel = RS_F; end
      `NCSRE_OPC_POP_X:    begin op = OP_POP_IDX; use_y = 1'b0; end
      `NCSRE_OPC_POP_Y:    begin op = OP_POP_IDX; use_y = 1'b1; end
      `NCSRE_OPC_PUSH_AB:  begin op = OP_PUSH_NIB; rsel = opcode[0] ? RS_A : RS_B; end
      `NCSRE_OPC_PUSH_F:   begin op = OP_PUSH_NIB; rsel = RS_F; end
      `NCSRE_OPC_PUSH_X:   begin op = OP_PUSH_IDX; use_y = 1'b0; end
      `NCSRE_OPC_PUSH_Y:   begin op = OP_PUSH_IDX; use_y = 1'b1; end
      `NCSRE_OPC_EXIT:     op = OP_EXIT;
      `NCSRE_OPC_EXIT_INT: op = OP_EXIT_INT;
      `NCSRE_OPC_EXIT_SKP: op = OP_EXIT_SKP;
      `NCSRE_OPC_EXIT_STB: op = OP_EXIT_STB;
      `NCSRE_OPC_ROT_L:    op = OP_ROT_L;
      `NCSRE_OPC_LD_AHI:   op = OP_LD_AHI;
      default:             op = OP_NOP;
    endcase
  end
endmodule
`default_nettype wire

// ---- ncsre_alu.sv ----
// Nibble logic unit: OR of two nibbles, or rotate left through carry.
// Assumes operands from flip-flops or memory read data on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ncsre_alu
(
  input  wire logic [3:0] opnd,
  input  wire logic [3:0] mask,
  input  wire logic       cin,
  input  wire logic       rotate,
  output var  logic [3:0] res,
  output var  logic       cout,
  output var  logic       zero
);
  always_comb
  begin
    res  = rotate ? {opnd[2:0], cin} : (opnd | mask);
    cout = rotate ? opnd[3] : cin;
    zero = (res == 4'h0);
  end
endmodule
`default_nettype wire

// ---- ncsre_core.sv ----
// Execution slice of a 4-bit core: memory OR forms, stack push and pop,
// the four exit variants and rotate left through carry.
// Assumes a data memory that answers a read one clock after the request
// and a 16-bit lane bus where lane n holds the nibble at address + n.
// Notes on behaviour
// - OR memory into register, then bump index
// - OR sets zero, clears E, keeps C, I
// - OR register into memory, read then write back
// - post-increment memory OR: write, then bump index
// - immediate OR into memory, pointer by opcode
// - post-increment immediate OR takes two cycles
// - post-increment forms ignore extended addressing
// - nibble pop loads register, then bumps pointer
// - word pop reads four nibbles, bumps pointer
// - nibble push writes below pointer, then decrements it
// - word push writes four nibbles below pointer, then decrements it
// - subroutine exit reloads program counter, bumps pointer
// - store-byte exit writes two nibbles, adds two
// - interrupt exit also restores flags from stack
// - skip exit adds one more to counter
// - rotate moves carry in, bit three out
// - loading high address byte sets E
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ncsre_consts.svh"
module ncsre_core
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        instr_valid,
  input  wire logic [12:0] instr,
  output var  logic        instr_ready,
  output var  logic [15:0] pc_q,
  output var  logic [15:0] dm_addr_q,
  output var  logic [15:0] dm_wdata_q,
  output var  logic [3:0]  dm_wen_q,
  output var  logic        dm_rd_q,
  input  wire logic [15:0] dm_rdata,
  input  wire logic [3:0]  rb_addr,
  input  wire logic [15:0] rb_wdata,
  input  wire logic        rb_we,
  input  wire logic        rb_re,
  output var  logic [15:0] rb_rdata_q
);
  import ncsre_pkg::*;

  ncsre_state_t state_q;
  ncsre_op_t    op_q;
  ncsre_rsel_t  rsel_q;
  ncsre_op_t    dec_op;
  ncsre_rsel_t  dec_rsel;
  logic         dec_use_y;
  logic         dec_inc;
  logic         use_y_q;
  logic         inc_q;
  logic [7:0]   imm_q;
  logic [15:0]  ea_q;
  logic [3:0]   a_q;
  logic [3:0]   b_q;
  logic [3:0]   f_q;
  logic [7:0]   addr_hi_q;
  logic [15:0]  x_q;
  logic [15:0]  y_q;
  logic [7:0]   rsp_q;
  logic [7:0]   nsp_q;
  logic         accept;
  logic         fin;
  logic         at_p1;
  logic         at_p3;
  logic [3:0]   reg_nib;
  logic [3:0]   alu_res;
  logic         alu_cout;
  logic         alu_zero;
  logic         is_or;
  logic         is_exit;
  logic [15:0]  idx_cur;

  function automatic logic [15:0] eff_addr(input logic [15:0] idx,
                                           input logic        use_y,
                                           input logic        inc,
                                           input logic        e_flag,
                                           input logic [7:0]  hi);
    if (e_flag && !inc)
      return {use_y ? `NCSRE_PAGE_Y : `NCSRE_PAGE_X, hi};
    return idx;
  endfunction

  function automatic ncsre_state_t last_step(input ncsre_op_t op);
    unique case (op)
      OP_OR_MEM_R, OP_OR_M_IMM, OP_EXIT_SKP, OP_EXIT_INT: return ST_P3;
      OP_EXIT_STB:                                        return ST_P5;
      default:                                            return ST_P1;
    endcase
  endfunction

  function automatic logic [3:0] pick_nib(input ncsre_rsel_t sel,
                                          input logic [3:0]  a,
                                          input logic [3:0]  b,
                                          input logic [3:0]  f);
    unique case (sel)
      RS_A:    return a;
      RS_B:    return b;
      RS_F:    return f;
      default: return `NCSRE_RST_NIB;
    endcase
  endfunction

  ncsre_decode u_decode
  (
    .opcode   (instr),
    .op       (dec_op),
    .rsel     (dec_rsel),
    .use_y    (dec_use_y),
    .post_inc (dec_inc)
  );

  // Operands come from flip-flops and read data; no stall path is needed.
  ncsre_alu u_alu
  (
    .opnd   ((op_q == OP_ROT_L) ? reg_nib : dm_rdata[3:0]),
    .mask   ((op_q == OP_OR_M_IMM) ? imm_q[3:0] : reg_nib),
    .cin    (f_q[`NCSRE_F_C]),
    .rotate (op_q == OP_ROT_L),
    .res    (alu_res),
    .cout   (alu_cout),
    .zero   (alu_zero)
  );

  // One idle clock between instructions lets pointer updates of the last
  // one settle before the next address is formed from them.
  assign instr_ready = (state_q == ST_IDLE);
  assign accept      = instr_valid && instr_ready;
  assign fin         = (state_q != ST_IDLE) && (state_q == last_step(op_q));
  assign at_p1       = (state_q == ST_P1);
  assign at_p3       = (state_q == ST_P3);
  assign reg_nib     = pick_nib(rsel_q, a_q, b_q, f_q);
  assign is_or       = (op_q == OP_OR_R_MEM) || (op_q == OP_OR_MEM_R) || (op_q == OP_OR_M_IMM);
  assign is_exit     = (op_q == OP_EXIT) || (op_q == OP_EXIT_SKP) ||
                       (op_q == OP_EXIT_INT) || (op_q == OP_EXIT_STB);
  assign idx_cur     = dec_use_y ? y_q : x_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= ST_IDLE;
    else if (accept)
      state_q <= ST_P0;
    else if (fin)
      state_q <= ST_IDLE;
    else if (state_q != ST_IDLE)
      state_q <= ncsre_state_t'(state_q + 3'b001);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_q    <= OP_NOP;
      rsel_q  <= RS_A;
      use_y_q <= 1'b0;
      inc_q   <= 1'b0;
      imm_q   <= `NCSRE_RST_BYTE;
      ea_q    <= `NCSRE_RST_WORD;
    end
    else if (accept)
    begin
      op_q    <= dec_op;
      rsel_q  <= dec_rsel;
      use_y_q <= dec_use_y;
      inc_q   <= dec_inc;
      imm_q   <= instr[7:0];
      ea_q    <= eff_addr(idx_cur, dec_use_y, dec_inc, f_q[`NCSRE_F_E], addr_hi_q);
    end
  end

  // Data memory requests; every strobe lasts one clock.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dm_addr_q  <= `NCSRE_RST_WORD;
      dm_wdata_q <= `NCSRE_RST_WORD;
      dm_wen_q   <= 4'h0;
      dm_rd_q    <= 1'b0;
    end
    else
    begin
      dm_wen_q <= 4'h0;
      dm_rd_q  <= 1'b0;
      if (accept)
      begin
        unique case (dec_op)
          OP_OR_R_MEM, OP_OR_MEM_R, OP_OR_M_IMM:
          begin
            dm_rd_q   <= 1'b1;
            dm_addr_q <= eff_addr(idx_cur, dec_use_y, dec_inc,
                                  f_q[`NCSRE_F_E], addr_hi_q);
          end
          OP_POP_NIB:
          begin
            dm_rd_q   <= 1'b1;
            dm_addr_q <= {`NCSRE_PAGE_STACK, nsp_q};
          end
          OP_POP_IDX, OP_EXIT, OP_EXIT_SKP, OP_EXIT_INT, OP_EXIT_STB:
          begin
            dm_rd_q   <= 1'b1;
            dm_addr_q <= {6'h00, rsp_q, 2'b00};
          end
          OP_PUSH_NIB:
          begin
            dm_wen_q   <= 4'h1;
            dm_addr_q  <= {`NCSRE_PAGE_STACK, nsp_q - 8'h01};
            dm_wdata_q <= {12'h000, pick_nib(dec_rsel, a_q, b_q, f_q)};
          end
          OP_PUSH_IDX:
          begin
            dm_wen_q   <= 4'hf;
            dm_addr_q  <= {6'h00, rsp_q - 8'h01, 2'b00};
            dm_wdata_q <= idx_cur;
          end
          default:
          begin
          end
        endcase
      end
      else if (at_p1 && (op_q == OP_OR_MEM_R || op_q == OP_OR_M_IMM))
      begin
        dm_wen_q   <= 4'h1;
        dm_addr_q  <= ea_q;
        dm_wdata_q <= {12'h000, alu_res};
      end
      else if (at_p1 && op_q == OP_EXIT_STB)
      begin
        dm_wen_q   <= 4'h1;
        dm_addr_q  <= x_q;
        dm_wdata_q <= {12'h000, imm_q[3:0]};
      end
      else if (at_p1 && op_q == OP_EXIT_INT)
      begin
        dm_rd_q   <= 1'b1;
        dm_addr_q <= {`NCSRE_PAGE_STACK, nsp_q};
      end
      else if (at_p3 && op_q == OP_EXIT_STB)
      begin
        dm_wen_q   <= 4'h1;
        dm_addr_q  <= x_q + 16'h0001;
        dm_wdata_q <= {12'h000, imm_q[7:4]};
      end
    end
  end

  // Nibble registers; execution wins over a port write in the same clock.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a_q <= `NCSRE_RST_NIB;
      b_q <= `NCSRE_RST_NIB;
    end
    else
    begin
      if (rb_we && rb_addr == `NCSRE_REG_A)
        a_q <= rb_wdata[3:0];
      if (rb_we && rb_addr == `NCSRE_REG_B)
        b_q <= rb_wdata[3:0];
      if (at_p1 && (op_q == OP_OR_R_MEM || op_q == OP_ROT_L || op_q == OP_POP_NIB))
      begin
        if (rsel_q == RS_A)
          a_q <= (op_q == OP_POP_NIB) ? dm_rdata[3:0] : alu_res;
        if (rsel_q == RS_B)
          b_q <= (op_q == OP_POP_NIB) ? dm_rdata[3:0] : alu_res;
      end
    end
  end

  // Flags: later assignments take priority over earlier ones.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      f_q <= `NCSRE_RST_NIB;
    else
    begin
      if (rb_we && rb_addr == `NCSRE_REG_F)
        f_q <= rb_wdata[3:0];
      if (fin)
        f_q[`NCSRE_F_E] <= (op_q == OP_LD_AHI);
      if (at_p1 && (is_or || op_q == OP_ROT_L))
        f_q[`NCSRE_F_Z] <= alu_zero;
      if (at_p1 && op_q == OP_ROT_L)
        f_q[`NCSRE_F_C] <= alu_cout;
      if (at_p1 && op_q == OP_POP_NIB && rsel_q == RS_F)
        f_q <= dm_rdata[3:0];
      if (at_p3 && op_q == OP_EXIT_INT)
        f_q <= dm_rdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      addr_hi_q <= `NCSRE_RST_BYTE;
    else if (fin && op_q == OP_LD_AHI)
      addr_hi_q <= imm_q;
    else if (rb_we && rb_addr == `NCSRE_REG_ADDR_HI)
      addr_hi_q <= rb_wdata[7:0];
  end

  // Index registers; post-increments never touch the flags.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x_q <= `NCSRE_RST_WORD;
      y_q <= `NCSRE_RST_WORD;
    end
    else
    begin
      if (rb_we && rb_addr == `NCSRE_REG_X)
        x_q <= rb_wdata;
      if (rb_we && rb_addr == `NCSRE_REG_Y)
        y_q <= rb_wdata;
      if (at_p1 && op_q == OP_POP_IDX)
      begin
        if (use_y_q)
          y_q <= dm_rdata;
        else
          x_q <= dm_rdata;
      end
      if (fin && is_or && inc_q)
      begin
        if (use_y_q)
          y_q <= y_q + 16'h0001;
        else
          x_q <= x_q + 16'h0001;
      end
      if (fin && op_q == OP_EXIT_STB)
        x_q <= x_q + 16'h0002;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_q <= `NCSRE_RST_BYTE;
      nsp_q <= `NCSRE_RST_BYTE;
    end
    else
    begin
      if (rb_we && rb_addr == `NCSRE_REG_RSP)
        rsp_q <= rb_wdata[7:0];
      if (rb_we && rb_addr == `NCSRE_REG_NSP)
        nsp_q <= rb_wdata[7:0];
      if (at_p1 && (op_q == OP_POP_IDX || is_exit))
        rsp_q <= rsp_q + 8'h01;
      if (at_p1 && op_q == OP_PUSH_IDX)
        rsp_q <= rsp_q - 8'h01;
      if ((at_p1 && op_q == OP_POP_NIB) || (at_p3 && op_q == OP_EXIT_INT))
        nsp_q <= nsp_q + 8'h01;
      if (at_p1 && op_q == OP_PUSH_NIB)
        nsp_q <= nsp_q - 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pc_q <= `NCSRE_RST_WORD;
    else if (at_p1 && is_exit)
      pc_q <= dm_rdata;
    else if (fin && (op_q == OP_EXIT_SKP || !is_exit))
      pc_q <= pc_q + 16'h0001;
    else if (rb_we && rb_addr == `NCSRE_REG_PC)
      pc_q <= rb_wdata;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rb_rdata_q <= `NCSRE_RST_WORD;
    else if (rb_re)
    begin
      unique case (rb_addr)
        `NCSRE_REG_A:       rb_rdata_q <= {12'h000, a_q};
        `NCSRE_REG_B:       rb_rdata_q <= {12'h000, b_q};
        `NCSRE_REG_F:       rb_rdata_q <= {12'h000, f_q};
        `NCSRE_REG_ADDR_HI: rb_rdata_q <= {8'h00, addr_hi_q};
        `NCSRE_REG_X:       rb_rdata_q <= x_q;
        `NCSRE_REG_Y:       rb_rdata_q <= y_q;
        `NCSRE_REG_RSP:     rb_rdata_q <= {8'h00, rsp_q};
        `NCSRE_REG_NSP:     rb_rdata_q <= {8'h00, nsp_q};
        `NCSRE_REG_PC:      rb_rdata_q <= pc_q;
        `NCSRE_REG_STATUS:  rb_rdata_q <= {12'h000, !instr_ready, state_q};
        default:            rb_rdata_q <= `NCSRE_RST_WORD;
      endcase
    end
    else
      rb_rdata_q <= `NCSRE_RST_WORD;
  end

  a_or_flags_kept: assert property (@(posedge mclk) disable iff (!arst_n)
    (at_p1 && op_q == OP_OR_R_MEM) |=> (f_q[2:1] == $past(f_q[2:1])) && !f_q[3])
    else $error("OR changed carry or interrupt flag");
  a_post_inc_plain: assert property (@(posedge mclk) disable iff (!arst_n)
    (accept && dec_op == OP_OR_M_IMM && dec_inc && !dec_use_y)
      |=> dm_rd_q && dm_addr_q == $past(x_q))
    else $error("post-increment form used a paged address");
  a_page_x_addr: assert property (@(posedge mclk) disable iff (!arst_n)
    (accept && dec_op == OP_OR_MEM_R && !dec_inc && !dec_use_y && f_q[3])
      |=> dm_addr_q == {8'h00, $past(addr_hi_q)})
    else $error("paged address wrong for first pointer");
  a_push_nib_dec: assert property (@(posedge mclk) disable iff (!arst_n)
    (accept && dec_op == OP_PUSH_NIB)
      |=> dm_wen_q == 4'h1 && dm_addr_q[7:0] == $past(nsp_q) - 8'h01
      ##2 nsp_q == $past(nsp_q, 3) - 8'h01)
    else $error("nibble push address or pointer wrong");
  a_push_word_addr: assert property (@(posedge mclk) disable iff (!arst_n)
    (accept && dec_op == OP_PUSH_IDX)
      |=> dm_wen_q == 4'hf && dm_addr_q == {6'h00, $past(rsp_q) - 8'h01, 2'b00})
    else $error("word push went to the wrong slot");
  a_pop_nib_inc: assert property (@(posedge mclk) disable iff (!arst_n)
    (at_p1 && op_q == OP_POP_NIB) |=> nsp_q == $past(nsp_q) + 8'h01)
    else $error("nibble pop did not bump its pointer");
  a_exit_pc_load: assert property (@(posedge mclk) disable iff (!arst_n)
    (at_p1 && is_exit) |=> pc_q == $past(dm_rdata) && rsp_q == $past(rsp_q) + 8'h01)
    else $error("exit did not reload the program counter");
  a_skip_exit_pc: assert property (@(posedge mclk) disable iff (!arst_n)
    (at_p1 && op_q == OP_EXIT_SKP) |-> ##3 pc_q == $past(dm_rdata, 3) + 16'h0001)
    else $error("skip exit did not skip one word");
  a_store_byte_seq: assert property (@(posedge mclk) disable iff (!arst_n)
    (at_p1 && op_q == OP_EXIT_STB)
      |=> dm_wen_q == 4'h1 && dm_wdata_q[3:0] == imm_q[3:0]
      ##2 dm_wen_q == 4'h1 && dm_addr_q == x_q + 16'h0001
      ##2 x_q == $past(x_q) + 16'h0002)
    else $error("store-byte exit sequence wrong");
  a_rot_carry: assert property (@(posedge mclk) disable iff (!arst_n)
    (at_p1 && op_q == OP_ROT_L && rsel_q == RS_A)
      |=> f_q[1] == $past(a_q[3]) && a_q[0] == $past(f_q[1]) && !f_q[3])
    else $error("rotate did not pass carry through");
endmodule
`default_nettype wire

// ---- ncsre_dmem.sv ----
// Nibble data memory standing at the far side of the execution slice.
// Assumes one clock; read data come one clock after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module ncsre_dmem
(
  input  wire logic        mclk,
  input  wire logic [15:0] dm_addr_q,
  input  wire logic [15:0] dm_wdata_q,
  input  wire logic [3:0]  dm_wen_q,
  input  wire logic        dm_rd_q,
  output var  logic [15:0] dm_rdata
);
  logic [3:0] mem [0:65535];
  initial dm_rdata = 16'h0;
  always @(posedge mclk)
  begin
    for (int i = 0; i < 4; i++)
      if (dm_wen_q[i])
        mem[dm_addr_q + 16'(i)] <= dm_wdata_q[4*i +: 4];
    // Outside a read answer the lanes toggle, so stale data never look valid.
    if (dm_rd_q)
      dm_rdata <= {mem[dm_addr_q + 16'h3], mem[dm_addr_q + 16'h2],
                   mem[dm_addr_q + 16'h1], mem[dm_addr_q]};
    else
      dm_rdata <= ~dm_rdata;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the nibble core execution slice.
// Assumes the memory model above and the register offsets of the header.
`timescale 1ns/10ps
`default_nettype none
`include "ncsre_consts.svh"
module testbench;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        instr_valid = 1'b0;
  logic        rb_we = 1'b0;
  logic        rb_re = 1'b0;
  logic        instr_ready;
  logic        dm_rd_q;
  logic [12:0] instr;
  logic [15:0] pc_q, dm_addr_q, dm_wdata_q, dm_rdata, rb_wdata, rb_rdata_q;
  logic [3:0]  dm_wen_q, rb_addr;
  int          err_count = 0;
  int          comparisons = 0;
  always #12.5 mclk = ~mclk;
  ncsre_core dut_u (.mclk, .arst_n, .instr_valid, .instr, .instr_ready, .pc_q,
    .dm_addr_q, .dm_wdata_q, .dm_wen_q, .dm_rd_q, .dm_rdata, .rb_addr,
    .rb_wdata, .rb_we, .rb_re, .rb_rdata_q);
  ncsre_dmem mem_u (.mclk, .dm_addr_q, .dm_wdata_q, .dm_wen_q, .dm_rd_q, .dm_rdata);
  task automatic close_out;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    rb_we <= 1'b1;
    rb_addr <= a;
    rb_wdata <= d;
    @(posedge mclk);
    rb_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    rb_re <= 1'b1;
    rb_addr <= a;
    @(posedge mclk);
    rb_re <= 1'b0;
    #1 chk(rb_rdata_q, e);
  endtask
  task automatic mchk(input logic [15:0] a, input logic [3:0] e);
    chk({12'h0, mem_u.mem[a]}, {12'h0, e});
  endtask
  // Issues one instruction and checks how long the sequencer stays busy.
  task automatic op(input logic [12:0] i, input int cyc);
    int n;
    n = 0;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= i;
    @(posedge mclk);
    instr_valid <= 1'b0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end while (instr_ready !== 1'b1 && n < 20);
    chk(16'(n), 16'(2 * cyc));
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    close_out;
  end
  initial
  begin
    instr = 13'h0;
    rb_addr = 4'h0;
    rb_wdata = 16'h0;
    mem_u.mem[16'h10] = 4'h5;
    mem_u.mem[16'h11] = 4'h0;
    mem_u.mem[16'h12] = 4'h0;
    mem_u.mem[16'h20] = 4'h3;
    mem_u.mem[16'h40] = 4'h0;
    mem_u.mem[16'h50] = 4'h0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd(`NCSRE_REG_PC, 16'h0);
    rd(4'hf, 16'h0);
    op(13'h1ffe, 1);
    rd(`NCSRE_REG_PC, 16'h1);
    wr(`NCSRE_REG_X, 16'h10);
    wr(`NCSRE_REG_Y, 16'h20);
    wr(`NCSRE_REG_A, 16'h2);
    wr(`NCSRE_REG_F, 16'h6);
    wr(`NCSRE_REG_RSP, 16'h10);
    wr(`NCSRE_REG_NSP, 16'h80);
    op(13'h1b61, 1);
    rd(`NCSRE_REG_A, 16'h7);
    rd(`NCSRE_REG_X, 16'h11);
    rd(`NCSRE_REG_F, 16'h6);
    op(13'h1b6c, 2);
    mchk(16'h11, 4'h0);
    rd(`NCSRE_REG_F, 16'h7);
    wr(`NCSRE_REG_B, 16'h8);
    op(13'h1b6d, 2);
    mchk(16'h11, 4'h8);
    rd(`NCSRE_REG_X, 16'h12);
    rd(`NCSRE_REG_F, 16'h6);
    op(13'h1b29, 2);
    mchk(16'h20, 4'hb);
    op(13'h0840, 1);
    rd(`NCSRE_REG_F, 16'he);
    op(13'h1b68, 2);
    mchk(16'h40, 4'h7);
    op(13'h0850, 1);
    op(13'h1b13, 2);
    mchk(16'h12, 4'h3);
    mchk(16'h50, 4'h0);
    rd(`NCSRE_REG_X, 16'h13);
    op(13'h1fe6, 1);
    mchk(16'h7f, 4'h8);
    op(13'h1fef, 1);
    rd(`NCSRE_REG_A, 16'h8);
    rd(`NCSRE_REG_NSP, 16'h80);
    op(13'h1fe1, 1);
    mchk(16'h3c, 4'h3);
    mchk(16'h3d, 4'h1);
    rd(`NCSRE_REG_RSP, 16'hf);
    op(13'h1ff8, 1);
    rd(`NCSRE_REG_PC, 16'h13);
    rd(`NCSRE_REG_RSP, 16'h10);
    op(13'h1fe2, 1);
    op(13'h1fe9, 1);
    rd(`NCSRE_REG_X, 16'h20);
    rd(`NCSRE_REG_RSP, 16'h10);
    op(13'h1fe1, 1);
    op(13'h1ffb, 2);
    rd(`NCSRE_REG_PC, 16'h21);
    op(13'h1fe1, 1);
    op(13'h1fe5, 1);
    wr(`NCSRE_REG_F, 16'h0);
    op(13'h1ff9, 2);
    rd(`NCSRE_REG_F, 16'h6);
    rd(`NCSRE_REG_NSP, 16'h80);
    op(13'h1fe1, 1);
    op(13'h11a5, 3);
    mchk(16'h20, 4'h5);
    mchk(16'h21, 4'ha);
    rd(`NCSRE_REG_X, 16'h22);
    op(13'h0800, 1);
    op(13'h10f2, 1);
    rd(`NCSRE_REG_A, 16'h1);
    rd(`NCSRE_REG_F, 16'h6);
    op(13'h10f2, 1);
    rd(`NCSRE_REG_A, 16'h3);
    rd(`NCSRE_REG_F, 16'h4);
    close_out;
  end
endmodule
`default_nettype wire
